// File: hw/conv_clk_div.sv
/*
  Converter clock divider producing a one-cycle enable per converter cycle.
  Assumes the oscillator arrives as a synchronous one-cycle tick.
*/
`timescale 1ns/1ns
`default_nettype none
module conv_clk_div
  import conv_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clear_i,
  input wire logic osc_tick_i,
  input wire logic src_bus_i,
  input wire logic [DIV_W-1:0] div_i,
  // Enable out
  output logic tick_o
);

  logic [3:0] cnt_q;
  logic [3:0] mask;
  logic src_tick;

  assign src_tick = src_bus_i | osc_tick_i;

  always_comb begin
    unique case (div_i)
      3'h0: mask = DIV_MASK_1;
      3'h1: mask = DIV_MASK_2;
      3'h2: mask = DIV_MASK_4;
      3'h3: mask = DIV_MASK_8;
      default: mask = DIV_MASK_16;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      tick_o <= 1'b0;
    end else if (clear_i) begin
      cnt_q <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= src_tick && (cnt_q >= mask);
      if (src_tick) begin
        cnt_q <= (cnt_q >= mask) ? 4'h0 : cnt_q + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// File: hw/conv_pkg.sv
/*
  Constants, field layout and types for the converter control block.
  Assumes a 32-bit AXI4-Lite bus and one 20 MHz bus clock.
*/
package conv_pkg;

  // Bus clock rate
  localparam int BUS_CLOCK_HZ = 20000000;

  // AXI4-Lite
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONFIG = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Status/control field positions
  localparam int SC_CONVERSION_COMPLETE_FLAG_BIT = 7;
  localparam int SC_CONVERSION_INTERRUPT_ENABLE_BIT = 6;
  localparam int SC_CONTINUOUS_CONVERSION_ENABLE_BIT = 5;
  localparam int SC_CH_LSB = 0;
  localparam int CH_W = 5;

  // Clock config field positions
  localparam int CK_DIV_LSB = 5;
  localparam int CK_SRC_BIT = 4;
  localparam int DIV_W = 3;

  // Channel codes
  localparam logic [CH_W-1:0] CH_PIN_LAST = 5'h07;
  localparam logic [CH_W-1:0] CH_REF_HIGH = 5'h1D;
  localparam logic [CH_W-1:0] CH_REF_LOW = 5'h1E;
  localparam logic [CH_W-1:0] CH_POWER_OFF = 5'h1F;
  localparam int PIN_COUNT = 8;

  // Reset values
  localparam logic [CH_W-1:0] CH_RESET = CH_POWER_OFF;
  localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
  localparam logic SRC_RESET = 1'b0;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Divider terminal counts
  localparam logic [3:0] DIV_MASK_1 = 4'h0;
  localparam logic [3:0] DIV_MASK_2 = 4'h1;
  localparam logic [3:0] DIV_MASK_4 = 4'h3;
  localparam logic [3:0] DIV_MASK_8 = 4'h7;
  localparam logic [3:0] DIV_MASK_16 = 4'hF;

  // Conversion length in converter clock cycles
  localparam logic [4:0] CONV_TICKS_MIN = 5'h10;
  localparam logic [4:0] CONV_TICKS_MAX = 5'h11;

  typedef struct packed {
    logic start;
    logic power_down;
    logic conv_tick;
    logic [CH_W-1:0] channel;
  } core_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_CONV
  } seq_state_t;

endpackage

// File: hw/sar_converter_control.sv
/*
  Control logic of an 8-bit eight-channel successive approximation
  converter: AXI4-Lite registers, pin takeover, sequencing, flag and
  interrupt, clock divider. Assumes an analog core that converts on the
  converter clock enable, and port logic that honours the enables here.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
// Function
// - Selected pin forced to converter input
// - Taken pin ignores port, reads zero
// - Result linear, all ones at high reference
// - Status write starts; 16 to 17 cycles
// - Continuous mode overwrites result every conversion
// - Continuous: flag holds until write or read
// - Single mode: one conversion per write
// - Flag read-only with interrupt disabled, cleared by write or read
// - Interrupt at conversion end while flag zero
// - Flag software-writable with interrupt enabled
// - Read or write removes pending interrupt
// - Reset clears flag, interrupt, continuous bits
// - Wait mode keeps converting, interrupt wakes
// - Stop aborts conversion, resumes after exit
// - All-ones channel powers converter off
// - Unused channel gives undefined result
// - Result register loaded on every completion
// - Divider field selects 1,2,4,8,16
// - Source select: one bus, zero oscillator
`timescale 1ns/1ns
`default_nettype none
module sar_converter_control
  import conv_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Clocking and power modes
  input wire logic OSC_TICK_I,
  input wire logic STOP_MODE_I,
  // Analog core
  output core_ctrl_t CORE_CTRL_O,
  input wire logic CORE_DONE_I,
  input wire logic [7:0] CORE_RESULT_I,
  // Shared port pins
  input wire logic [PIN_COUNT-1:0] PIN_IN_I,
  input wire logic [PIN_COUNT-1:0] PORT_DRIVE_EN_I,
  output logic [PIN_COUNT-1:0] PIN_OE_O,
  output logic [PIN_COUNT-1:0] PORT_READ_O,
  // Interrupt request
  output logic IRQ_O
);

  // Bus slave state
  logic aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic rd_fire;
  logic scr_write;
  logic res_read;
  logic wr_mapped;

  // Registers
  logic conversion_complete_flag_q;
  logic conversion_interrupt_enable_q;
  logic continuous_conversion_enable_q;
  logic [CH_W-1:0] channel_q;
  logic [DIV_W-1:0] div_q;
  logic src_bus_q;
  logic [7:0] result_q;
  logic irq_pend_q;
  logic [7:0] scr_value;
  logic [7:0] clk_value;

  // Sequencer
  seq_state_t state_q;
  logic [4:0] tick_cnt_q;
  logic [4:0] tick_next;
  logic start_q;
  logic conv_done;
  logic resume_q;
  logic stop_q;
  logic conv_tick;
  logic powered_off;
  logic [PIN_COUNT-1:0] takeover;

  assign S_AXI_AWREADY_O = !aw_full_q && !bvalid_q;
  assign S_AXI_WREADY_O = !w_full_q && !bvalid_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = !rvalid_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign S_AXI_RDATA_O = rdata_q;

  // Write takes effect once both halves are held
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign rd_fire = S_AXI_ARVALID_I && !rvalid_q;
  assign wr_mapped = (aw_addr_q == ADDR_STATUS_CONTROL) || (aw_addr_q == ADDR_RESULT)
    || (aw_addr_q == ADDR_CLOCK_CONFIG);
  assign scr_write = wr_fire && (aw_addr_q == ADDR_STATUS_CONTROL) && w_strb_q[0];
  assign res_read = rd_fire && (S_AXI_ARADDR_I == ADDR_RESULT);

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= ADDR_STATUS_CONTROL;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR_I;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      w_full_q <= 1'b0;
      w_data_q <= READ_ZERO;
      w_strb_q <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_full_q <= 1'b1;
      w_data_q <= S_AXI_WDATA_I;
      w_strb_q <= S_AXI_WSTRB_I;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_q <= 1'b0;
    end
  end

  assign scr_value = {conversion_complete_flag_q, conversion_interrupt_enable_q, continuous_conversion_enable_q, channel_q};
  assign clk_value = {div_q, src_bus_q, 4'h0};

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= READ_ZERO;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      unique case (S_AXI_ARADDR_I)
        ADDR_STATUS_CONTROL: rdata_q <= {24'h00_0000, scr_value};
        ADDR_RESULT: rdata_q <= {24'h00_0000, result_q};
        ADDR_CLOCK_CONFIG: rdata_q <= {24'h00_0000, clk_value};
        default: begin
          rdata_q <= READ_ZERO;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY_I) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control fields of the status/control register
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      conversion_interrupt_enable_q <= 1'b0;
      continuous_conversion_enable_q <= 1'b0;
      channel_q <= CH_RESET;
    end else if (scr_write) begin
      conversion_interrupt_enable_q <= w_data_q[SC_CONVERSION_INTERRUPT_ENABLE_BIT];
      continuous_conversion_enable_q <= w_data_q[SC_CONTINUOUS_CONVERSION_ENABLE_BIT];
      channel_q <= w_data_q[SC_CH_LSB +: CH_W];
    end
  end

  // Clock configuration
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_q <= DIV_RESET;
      src_bus_q <= SRC_RESET;
    end else if (wr_fire && (aw_addr_q == ADDR_CLOCK_CONFIG) && w_strb_q[0]) begin
      div_q <= w_data_q[CK_DIV_LSB +: DIV_W];
      src_bus_q <= w_data_q[CK_SRC_BIT];
    end
  end

  // Completion flag; a completion in the clearing cycle wins
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      conversion_complete_flag_q <= 1'b0;
    end else if (conv_done && !conversion_interrupt_enable_q) begin
      conversion_complete_flag_q <= 1'b1;
    end else if (scr_write) begin
      conversion_complete_flag_q <= w_data_q[SC_CONVERSION_INTERRUPT_ENABLE_BIT] ? w_data_q[SC_CONVERSION_COMPLETE_FLAG_BIT] : 1'b0;
    end else if (res_read && !conversion_interrupt_enable_q) begin
      conversion_complete_flag_q <= 1'b0;
    end
  end

  // Pending request; set beats clear
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      irq_pend_q <= 1'b0;
    end else if (conv_done && conversion_interrupt_enable_q) begin
      irq_pend_q <= 1'b1;
    end else if (scr_write || res_read) begin
      irq_pend_q <= 1'b0;
    end
  end

  // Not gated by wait mode, so it can wake the processor
  assign IRQ_O = irq_pend_q && conversion_interrupt_enable_q && !conversion_complete_flag_q;

  // Result capture, overwritten even if unread
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      result_q <= RESULT_RESET;
    end else if (conv_done) begin
      result_q <= CORE_RESULT_I;
    end
  end

  assign powered_off = (channel_q == CH_POWER_OFF);

  conv_clk_div u_div (
    .clk_i(MCLK_I),
    .rst_n_i(ARST_N_I),
    .clear_i(STOP_MODE_I || powered_off),
    .osc_tick_i(OSC_TICK_I),
    .src_bus_i(src_bus_q),
    .div_i(div_q),
    .tick_o(conv_tick)
  );

  // Core may finish early from the sixteenth cycle; seventeen is the cap
  assign tick_next = tick_cnt_q + 5'h01;
  assign conv_done = (state_q == ST_CONV) && conv_tick && !STOP_MODE_I
    && ((CORE_DONE_I && (tick_next >= CONV_TICKS_MIN)) || (tick_next == CONV_TICKS_MAX));

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= STOP_MODE_I;
    end
  end

  // Remembers work to redo after stop exit
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      resume_q <= 1'b0;
    end else if (STOP_MODE_I && !stop_q) begin
      resume_q <= (state_q != ST_IDLE) || continuous_conversion_enable_q;
    end else if (!STOP_MODE_I) begin
      resume_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q <= ST_IDLE;
      tick_cnt_q <= 5'h00;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (STOP_MODE_I) begin
        state_q <= ST_IDLE;
        tick_cnt_q <= 5'h00;
      end else if (scr_write) begin
        // New write restarts any conversion under way, or ends it if it selects power-off
        state_q <= (w_data_q[SC_CH_LSB +: CH_W] == CH_POWER_OFF) ? ST_IDLE : ST_ARM;
        tick_cnt_q <= 5'h00;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (stop_q && resume_q && !powered_off) begin
              state_q <= ST_ARM;
            end
          end
          ST_ARM: begin
            if (conv_tick) begin
              start_q <= 1'b1;
              tick_cnt_q <= 5'h01;
              state_q <= ST_CONV;
            end
          end
          ST_CONV: begin
            if (conv_done) begin
              tick_cnt_q <= 5'h00;
              state_q <= continuous_conversion_enable_q ? ST_ARM : ST_IDLE;
            end else if (conv_tick) begin
              tick_cnt_q <= tick_next;
            end
          end
        endcase
      end
    end
  end

  always_comb begin
    CORE_CTRL_O.start = start_q;
    CORE_CTRL_O.power_down = powered_off || STOP_MODE_I;
    CORE_CTRL_O.conv_tick = conv_tick;
    CORE_CTRL_O.channel = channel_q;
  end

  // Pin takeover, registered so reads and enables come from flops
  logic [PIN_COUNT-1:0] oe_q;
  logic [PIN_COUNT-1:0] read_q;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
      assign takeover[gi] = (channel_q <= CH_PIN_LAST) && (channel_q[2:0] == 3'(gi));
      always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
          oe_q[gi] <= 1'b0;
          read_q[gi] <= 1'b0;
        end else begin
          oe_q[gi] <= PORT_DRIVE_EN_I[gi] && !takeover[gi];
          read_q[gi] <= PIN_IN_I[gi] && !takeover[gi];
        end
      end
    end
  endgenerate

  assign PIN_OE_O = oe_q;
  assign PORT_READ_O = read_q;

endmodule
`default_nettype wire

// File: tb/conv_monitor.sv
/*
  Port checker for the converter control block.
  Bound into its top module; sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module conv_monitor
  import conv_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  // Bus handshakes
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  // Core and pins
  input wire logic STOP_MODE_I,
  input wire core_ctrl_t CORE_CTRL_O,
  input wire logic [PIN_COUNT-1:0] PIN_IN_I,
  input wire logic [PIN_COUNT-1:0] PORT_DRIVE_EN_I,
  input wire logic [PIN_COUNT-1:0] PIN_OE_O,
  input wire logic [PIN_COUNT-1:0] PORT_READ_O
);
  wire [CH_W-1:0] ch = CORE_CTRL_O.channel;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Takeover is registered, so a changing channel is not judged
  property p_pin_taken;
    $stable(ch) && ch <= CH_PIN_LAST |-> !PIN_OE_O[ch[2:0]] && !PORT_READ_O[ch[2:0]];
  endproperty
  a_pin_taken: assert property (p_pin_taken) else $error("Taken pin left to port");
  property p_pin_free;
    $past(ARST_N_I) && ch > CH_PIN_LAST && $stable(ch) && $stable(PORT_DRIVE_EN_I) && $stable(PIN_IN_I)
      |-> PIN_OE_O == PORT_DRIVE_EN_I && PORT_READ_O == PIN_IN_I;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("Free pin not passed through");
  property p_power_off;
    ch == CH_POWER_OFF |-> CORE_CTRL_O.power_down;
  endproperty
  a_power_off: assert property (p_power_off) else $error("Core not off");
  property p_stop_off;
    STOP_MODE_I |-> CORE_CTRL_O.power_down;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("Core active in stop");
  property p_off_quiet;
    CORE_CTRL_O.power_down [*3] |-> !CORE_CTRL_O.start && !CORE_CTRL_O.conv_tick;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("Core driven while off");
  property p_read_answer;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("Read not answered");
  property p_read_block;
    S_AXI_RVALID_O |-> !S_AXI_ARREADY_O;
  endproperty
  a_read_block: assert property (p_read_block) else $error("Read taken while busy");
  property p_write_block;
    S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
  endproperty
  a_write_block: assert property (p_write_block) else $error("Write taken while busy");
endmodule

bind sar_converter_control conv_monitor mon_u (.*);
`default_nettype wire

// File: tb/core_model.sv
/*
  Behavioural analog core: counts converter ticks after a start.
  Assumes the control block's core bus on one clock.
*/
`timescale 1ns/1ns
`default_nettype none
module core_model
  import conv_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control in
  input wire core_ctrl_t ctrl_i,
  // Answer out
  output logic done_o,
  output logic [7:0] result_o,
  output logic [7:0] runs_o
);
  logic [4:0] ticks_q;
  logic [7:0] wobble_q;
  // Idle is the saturated count, so a stray tick never finishes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ticks_q <= 5'h10;
    end else if (ctrl_i.power_down) begin
      ticks_q <= 5'h10;
    end else if (ctrl_i.start) begin
      ticks_q <= {4'h0, ctrl_i.conv_tick};
    end else if (ctrl_i.conv_tick && ticks_q < 5'h10) begin
      ticks_q <= ticks_q + 5'h01;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      runs_o <= 8'h00;
      wobble_q <= 8'h5A;
    end else begin
      wobble_q <= ~wobble_q;
      if (ctrl_i.start) begin
        runs_o <= runs_o + 8'h01;
      end
    end
  end
  assign done_o = ctrl_i.conv_tick && ticks_q == 5'h0F && !ctrl_i.power_down && !ctrl_i.start;
  always_comb begin
    case (ctrl_i.channel)
      CH_REF_HIGH: result_o = 8'hFF;
      CH_REF_LOW: result_o = 8'h00;
      default: result_o = ctrl_i.channel <= CH_PIN_LAST ? {ctrl_i.channel[2:0], runs_o[4:0]} : wobble_q;
    endcase
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
/*
  Self-checking bench for the converter control block.
  Drives AXI4-Lite, pins and stop mode; core_model answers the core bus.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
  import conv_pkg::*;
();
  logic MCLK_I = 1'b0;
  logic ARST_N_I = 1'b0;
  logic [ADDR_W-1:0] S_AXI_AWADDR_I = 4'h0;
  logic S_AXI_AWVALID_I = 1'b0;
  logic S_AXI_AWREADY_O;
  logic [31:0] S_AXI_WDATA_I = 32'h0000_0000;
  logic [3:0] S_AXI_WSTRB_I = 4'hF;
  logic S_AXI_WVALID_I = 1'b0;
  logic S_AXI_WREADY_O;
  logic [1:0] S_AXI_BRESP_O;
  logic S_AXI_BVALID_O;
  logic S_AXI_BREADY_I = 1'b0;
  logic [ADDR_W-1:0] S_AXI_ARADDR_I = 4'h0;
  logic S_AXI_ARVALID_I = 1'b0;
  logic S_AXI_ARREADY_O;
  logic [31:0] S_AXI_RDATA_O;
  logic [1:0] S_AXI_RRESP_O;
  logic S_AXI_RVALID_O;
  logic S_AXI_RREADY_I = 1'b0;
  logic OSC_TICK_I = 1'b0;
  logic STOP_MODE_I = 1'b0;
  core_ctrl_t CORE_CTRL_O;
  logic CORE_DONE_I;
  logic [7:0] CORE_RESULT_I;
  logic [PIN_COUNT-1:0] PIN_IN_I = 8'hFF;
  logic [PIN_COUNT-1:0] PORT_DRIVE_EN_I = 8'hFF;
  logic [PIN_COUNT-1:0] PIN_OE_O;
  logic [PIN_COUNT-1:0] PORT_READ_O;
  logic IRQ_O;
  logic [7:0] runs;
  logic [7:0] n0;
  logic [31:0] rdat;
  logic [31:0] r1;
  logic [1:0] osc = 2'h0;
  int bad_count = 0;
  int checks = 0;
  int gap = 0;
  int since = 0;
  int ticks = 0;

  always #25 MCLK_I = ~MCLK_I;
  sar_converter_control dut_u (.*);
  core_model core_u (.clk_i(MCLK_I), .rst_n_i(ARST_N_I), .ctrl_i(CORE_CTRL_O), .done_o(CORE_DONE_I),
    .result_o(CORE_RESULT_I), .runs_o(runs));

  // Oscillator tick every third cycle; converter tick spacing and count
  always @(posedge MCLK_I) begin
    osc <= (osc == 2'h2) ? 2'h0 : osc + 2'h1;
    OSC_TICK_I <= (osc == 2'h2);
    since = since + 1;
    if (CORE_CTRL_O.start) begin
      ticks = 0;
    end
    if (CORE_CTRL_O.conv_tick) begin
      gap = since;
      since = 0;
      ticks = ticks + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [1:0] resp_of(input logic [3:0] a);
    return (a > ADDR_CLOCK_CONFIG) ? RESP_SLVERR : RESP_OKAY;
  endfunction

  // Starts one edge late so no signal is assigned twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= {24'h00_0000, d};
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    // Only the watchdog ends a wait
    do begin
      @(posedge MCLK_I);
      if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
    end while (S_AXI_BVALID_O !== 1'b1);
    S_AXI_BREADY_I <= 1'b0;
    chk({30'h0, S_AXI_BRESP_O}, {30'h0, resp_of(a)});
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge MCLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do begin
      @(posedge MCLK_I);
      if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
    end while (S_AXI_RVALID_O !== 1'b1);
    S_AXI_RREADY_I <= 1'b0;
    rdat = S_AXI_RDATA_O;
    chk({30'h0, S_AXI_RRESP_O}, {30'h0, resp_of(a)});
  endtask

  task automatic wait_conversion_complete_flag();
    int n;
    n = 0;
    do begin
      rd(ADDR_STATUS_CONTROL);
      n++;
    end while (rdat[7] !== 1'b1 && n < 200);
    chk({31'h0, rdat[7]}, 32'h0000_0001);
  endtask

  task automatic conclude();
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge MCLK_I);
    ARST_N_I <= 1'b1;
    rd(ADDR_STATUS_CONTROL);
    chk(rdat, 32'h0000_001F);
    rd(ADDR_RESULT);
    chk(rdat, 32'h0000_0000);
    rd(ADDR_CLOCK_CONFIG);
    chk(rdat, 32'h0000_0000);
    // Low byte lane off, so the write must not land
    S_AXI_WSTRB_I <= 4'hE;
    wr(ADDR_CLOCK_CONFIG, 8'hF0);
    S_AXI_WSTRB_I <= 4'hF;
    rd(ADDR_CLOCK_CONFIG);
    chk(rdat, 32'h0000_0000);
    rd(4'hC);
    wr(4'hC, 8'hFF);
    wr(ADDR_STATUS_CONTROL, 8'h1D);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CLOCK_CONFIG, {c[2:0], 5'h10});
      repeat (40) @(posedge MCLK_I);
      chk(gap, c[2] ? 16 : 1 << c);
    end
    wr(ADDR_CLOCK_CONFIG, 8'h20);
    repeat (40) @(posedge MCLK_I);
    chk(gap, 32'h0000_0006);
    // Bus over sixteen is nearest one megahertz; poll stays under one tick
    wr(ADDR_CLOCK_CONFIG, 8'h90);
    n0 = runs;
    wr(ADDR_STATUS_CONTROL, 8'h1D);
    wait_conversion_complete_flag();
    chk({31'h0, ticks >= 16 && ticks <= 18}, 32'h0000_0001);
    rd(ADDR_RESULT);
    chk(rdat, 32'h0000_00FF);
    rd(ADDR_STATUS_CONTROL);
    chk(rdat, 32'h0000_001D);
    repeat (300) @(posedge MCLK_I);
    chk(runs - n0, 32'h0000_0001);
    PORT_DRIVE_EN_I <= 8'hF0;
    wr(ADDR_STATUS_CONTROL, 8'h05);
    repeat (3) @(posedge MCLK_I);
    chk({PIN_OE_O, PORT_READ_O}, 32'h0000_D0DF);
    wait_conversion_complete_flag();
    rd(ADDR_RESULT);
    chk(rdat[7:5], 3'h5);
    wr(ADDR_STATUS_CONTROL, 8'h1E);
    wait_conversion_complete_flag();
    rd(ADDR_RESULT);
    chk(rdat, 32'h0000_0000);
    wr(ADDR_STATUS_CONTROL, 8'h22);
    wait_conversion_complete_flag();
    repeat (300) @(posedge MCLK_I);
    rd(ADDR_STATUS_CONTROL);
    chk(rdat, 32'h0000_00A2);
    rd(ADDR_RESULT);
    r1 = rdat;
    wait_conversion_complete_flag();
    rd(ADDR_RESULT);
    chk({31'h0, rdat !== r1}, 32'h0000_0001);
    chk(rdat[7:5], 3'h2);
    wr(ADDR_STATUS_CONTROL, 8'h02);
    repeat (400) @(posedge MCLK_I);
    n0 = runs;
    repeat (300) @(posedge MCLK_I);
    chk(runs - n0, 32'h0000_0000);
    wr(ADDR_STATUS_CONTROL, 8'h43);
    for (int n = 0; n < 400 && IRQ_O !== 1'b1; n++) @(posedge MCLK_I);
    chk(IRQ_O, 1'b1);
    rd(ADDR_STATUS_CONTROL);
    chk(rdat, 32'h0000_0043);
    rd(ADDR_RESULT);
    chk(IRQ_O, 1'b0);
    wr(ADDR_STATUS_CONTROL, 8'h43);
    for (int n = 0; n < 400 && IRQ_O !== 1'b1; n++) @(posedge MCLK_I);
    chk(IRQ_O, 1'b1);
    wr(ADDR_STATUS_CONTROL, 8'hC3);
    chk(IRQ_O, 1'b0);
    rd(ADDR_STATUS_CONTROL);
    chk(rdat, 32'h0000_00C3);
    repeat (400) @(posedge MCLK_I);
    chk(IRQ_O, 1'b0);
    wr(ADDR_STATUS_CONTROL, 8'h01);
    repeat (50) @(posedge MCLK_I);
    STOP_MODE_I <= 1'b1;
    repeat (300) @(posedge MCLK_I);
    rd(ADDR_STATUS_CONTROL);
    chk(rdat, 32'h0000_0001);
    STOP_MODE_I <= 1'b0;
    // First result after stop only settles the analog side
    wait_conversion_complete_flag();
    wr(ADDR_STATUS_CONTROL, 8'h1F);
    n0 = runs;
    repeat (300) @(posedge MCLK_I);
    chk(runs - n0, 32'h0000_0000);
    chk(CORE_CTRL_O.power_down, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
